// *** hw/rlc_ctrl.sv ***
// regenerator loopback 1a control with ahb-lite register slave
// assumes transceiver status and eoc strobes are synchronous to hclk
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module rlc_ctrl (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // line transceiver status
  input wire logic los_lfa_net,
  input wire logic los_lfa_cust,
  input wire logic net_link_active,
  // received eoc message from the ltu
  input wire logic eoc_rx_valid,
  input wire logic [1:0] eoc_rx_addr,
  input wire logic [7:0] eoc_rx_code,
  // indicator bits
  input wire logic [7:0] ind_rx_net,
  input wire logic [7:0] ind_rx_cust,
  input wire logic [7:0] ind_local,
  output logic [7:0] ind_tx_net,
  // eoc actions
  output logic eoc_tx_valid,
  output logic [1:0] eoc_tx_addr,
  output logic [7:0] eoc_tx_code,
  output logic eoc_own_strobe,
  output logic eoc_fwd_strobe,
  // transceiver control
  output logic deact_net,
  output logic deact_cust,
  output logic cust_xcvr_rst,
  output logic cust_start,
  output logic loop_en,
  output logic cust_fwd_en,
  // interrupt
  output logic irq
);
  typedef struct packed {
    rlc_pkg::rlc_state_t state;
    logic [7:0] rst_cnt;
    logic loop_en;
    logic fwd_en;
    logic xcvr_rst;
    logic deact_net;
    logic deact_cust;
    logic cust_start;
    logic tx_valid;
    logic [7:0] tx_code;
    logic own_stb;
    logic fwd_stb;
    logic [7:0] ind_tx;
    logic ctrl_rst_en;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic irq;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } rlc_ctrl_state_t;

  rlc_ctrl_state_t s_r;
  rlc_ctrl_state_t s_nxt;
  logic own_msg;
  logic other_msg;
  logic loop_req;
  logic rtn_req;
  logic addr_phase;
  logic los_any;
  logic [3:0] ev;

  rlc_eoc_decode u_dec (
    .valid(eoc_rx_valid),
    .addr(eoc_rx_addr),
    .code(eoc_rx_code),
    .own_msg(own_msg),
    .other_msg(other_msg),
    .loop_req(loop_req),
    .rtn_req(rtn_req)
  );

  // a transfer is taken when selected, nonsequential/sequential and bus ready
  assign addr_phase = hsel && hready && htrans[1];
  assign los_any = los_lfa_net || los_lfa_cust;

  // next-state logic for the loop machine, eoc handling and registers
  always_comb begin
    s_nxt = s_r;
    ev = 4'h0;
    // single-cycle strobes drop by default
    s_nxt.deact_net = 1'b0;
    s_nxt.deact_cust = 1'b0;
    s_nxt.cust_start = 1'b0;
    s_nxt.tx_valid = 1'b0;
    s_nxt.own_stb = 1'b0;
    s_nxt.fwd_stb = 1'b0;

    if (los_any) begin
      // loss on either line takes down both sides, no command awaited
      s_nxt.deact_net = 1'b1;
      s_nxt.deact_cust = 1'b1;
      s_nxt.loop_en = 1'b0; // loss also clears a standing loop
      s_nxt.xcvr_rst = 1'b0;
      s_nxt.fwd_en = 1'b1;
      s_nxt.state = rlc_pkg::ST_NORMAL;
      ev[rlc_pkg::EV_LOSS] = 1'b1;
      if (s_r.state != rlc_pkg::ST_NORMAL) begin
        ev[rlc_pkg::EV_LOOP_OFF] = 1'b1;
      end
    end else begin
      case (s_r.state)
        rlc_pkg::ST_NORMAL: begin
          // loop is closed only on the ltu's request, start-up or active
          if (loop_req) begin
            s_nxt.loop_en = 1'b1; // closed as soon as detected
            s_nxt.fwd_en = 1'b1; // stays transparent toward the ntu
            ev[rlc_pkg::EV_LOOP_ON] = 1'b1;
            if (s_r.ctrl_rst_en) begin
              // reset lets the customer-side coefficients reconverge
              s_nxt.xcvr_rst = 1'b1;
              s_nxt.rst_cnt = rlc_pkg::RST_CNT_LOAD;
              s_nxt.state = rlc_pkg::ST_LOOP_RST;
            end else begin
              s_nxt.state = rlc_pkg::ST_LOOP;
            end
          end
          // out of loop: own messages handled here, others pass on
          s_nxt.own_stb = own_msg && !loop_req;
          s_nxt.fwd_stb = other_msg;
        end
        rlc_pkg::ST_LOOP_RST, rlc_pkg::ST_LOOP: begin
          if (s_r.state == rlc_pkg::ST_LOOP_RST) begin
            if (s_r.rst_cnt == 8'h00) begin
              s_nxt.xcvr_rst = 1'b0;
              s_nxt.state = rlc_pkg::ST_LOOP;
            end else begin
              s_nxt.rst_cnt = s_r.rst_cnt - 8'h01;
            end
          end
          if (rtn_req) begin
            // return to normal: cancel and drop the customer side
            s_nxt.loop_en = 1'b0;
            s_nxt.xcvr_rst = 1'b0;
            s_nxt.deact_cust = 1'b1;
            s_nxt.state = rlc_pkg::ST_NORMAL;
            ev[rlc_pkg::EV_LOOP_OFF] = 1'b1;
            // net side still up: start-up toward the ntu right away
            s_nxt.cust_start = net_link_active;
          end else if (other_msg) begin
            // foreign address while looped: answer hold state ourselves
            s_nxt.tx_valid = 1'b1;
            s_nxt.tx_code = rlc_pkg::CODE_HOLD;
            ev[rlc_pkg::EV_HOLD] = 1'b1;
          end
          // own-address traffic keeps running normally, not looped
          s_nxt.own_stb = own_msg && !rtn_req;
        end
        default: begin
          s_nxt.state = rlc_pkg::ST_NORMAL;
          s_nxt.loop_en = 1'b0;
          s_nxt.xcvr_rst = 1'b0;
        end
      endcase
    end

    // indicators toward the ltu: looped copy when looped, else customer-side copy; local regenerator bits kept
    if (s_nxt.loop_en) begin
      s_nxt.ind_tx = rlc_pkg::rlc_ind_merge(ind_rx_net, ind_local);
    end else begin
      s_nxt.ind_tx = rlc_pkg::rlc_ind_merge(ind_rx_cust, ind_local);
    end

    // write data phase: data stands now, address was captured last cycle
    s_nxt.wr_pend = 1'b0;
    if (s_r.wr_pend) begin
      case (s_r.wr_addr)
        rlc_pkg::CTRL_OFF: s_nxt.ctrl_rst_en = hwdata[0];
        rlc_pkg::IRQ_MASK_OFF: s_nxt.irq_mask = hwdata[3:0];
        default: s_nxt.ctrl_rst_en = s_nxt.ctrl_rst_en;
      endcase
    end

    // address phase: reads are fetched here so data is ready in the data phase
    if (addr_phase) begin
      s_nxt.wr_pend = hwrite;
      s_nxt.wr_addr = haddr;
      s_nxt.rdata = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr)
          rlc_pkg::CTRL_OFF: s_nxt.rdata = {31'h0000_0000, s_r.ctrl_rst_en};
          rlc_pkg::STAT_OFF: s_nxt.rdata = {24'h00_0000, s_r.xcvr_rst, net_link_active,
                                            los_lfa_cust, los_lfa_net, s_r.fwd_en,
                                            s_r.loop_en, s_r.state};
          rlc_pkg::IRQ_STAT_OFF: s_nxt.rdata = {28'h000_0000, s_r.irq_stat};
          rlc_pkg::IRQ_MASK_OFF: s_nxt.rdata = {28'h000_0000, s_r.irq_mask};
          default: s_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end

    // sticky events; read clears but a same-cycle event still wins
    if (addr_phase && !hwrite && (haddr == rlc_pkg::IRQ_STAT_OFF)) begin
      s_nxt.irq_stat = ev;
    end else begin
      s_nxt.irq_stat = s_r.irq_stat | ev;
    end
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  // single register stage for all state; reset gives constants only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.state <= rlc_pkg::ST_NORMAL;
      s_r.fwd_en <= 1'b1;
      s_r.ctrl_rst_en <= rlc_pkg::CTRL_RST;
      s_r.irq_mask <= rlc_pkg::IRQ_MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register, eoc_tx_addr a constant; slave never waits nor errors
  assign hrdata = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ind_tx_net = s_r.ind_tx;
  assign eoc_tx_valid = s_r.tx_valid;
  assign eoc_tx_addr = rlc_pkg::OWN_ADDR; // hold state always carries our address
  assign eoc_tx_code = s_r.tx_code;
  assign eoc_own_strobe = s_r.own_stb;
  assign eoc_fwd_strobe = s_r.fwd_stb;
  assign deact_net = s_r.deact_net;
  assign deact_cust = s_r.deact_cust;
  assign cust_xcvr_rst = s_r.xcvr_rst;
  assign cust_start = s_r.cust_start;
  assign loop_en = s_r.loop_en;
  assign cust_fwd_en = s_r.fwd_en;
  assign irq = s_r.irq;
endmodule

// *** hw/rlc_pkg.sv ***
// constants, state type and register map of the regenerator loopback control
// assumes one 200 MHz clock; eoc messages arrive already deframed
// Operation
// - los/lfa either side deactivates both sides
// - start-up: close loop on detected request
// - active link: close at once, optional reset
// - looped signal still forwarded toward ntu
// - eoc to address 10 handled normally
// - other address: send hold state, own address
// - indicators looped except hrp rega rrbe rcbe
// - return to normal: deactivate customer side, cancel
// - ltu link active: restart ntu side at once
package rlc_pkg;
  // eoc addressing and message codes (codes are plain defaults)
  localparam logic [1:0] OWN_ADDR = 2'h2;
  localparam int EOC_W = 8;
  localparam logic [7:0] CODE_LOOP_REQ = 8'h50;
  localparam logic [7:0] CODE_RTN = 8'h01;
  localparam logic [7:0] CODE_HOLD = 8'h02;
  // indicator bits; regenerator-specific ones keep local values
  localparam int IND_W = 8;
  localparam logic [7:0] REG_IND_MASK = 8'hF0;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h0C;
  // reset values
  localparam logic CTRL_RST = 1'b1;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  // interrupt status bit positions
  localparam int EV_LOOP_ON = 0;
  localparam int EV_LOOP_OFF = 1;
  localparam int EV_LOSS = 2;
  localparam int EV_HOLD = 3;
  // customer-side transceiver reset pulse on loop close
  localparam int CLK_MHZ = 200;
  localparam int RST_TIME_NS = 1000;
  localparam int RST_CYC_RAW = (RST_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
  localparam logic [7:0] RST_CNT_LOAD = 8'(RST_CYC - 1);

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_LOOP_RST = 2'b01,
    ST_LOOP = 2'b10
  } rlc_state_t;

  // merge looped indicators with the locally generated regenerator bits
  function automatic logic [7:0] rlc_ind_merge(input logic [7:0] pass, input logic [7:0] loc);
    rlc_ind_merge = (pass & ~REG_IND_MASK) | (loc & REG_IND_MASK);
  endfunction
endpackage

// *** hw/rlc_eoc_decode.sv ***
// classifier for one received eoc message
// assumes valid is a one-cycle strobe with address and code stable beside it
`timescale 1ns/10ps
module rlc_eoc_decode (
  // received message
  input wire logic valid,
  input wire logic [1:0] addr,
  input wire logic [7:0] code,
  // classification, combinational
  output logic own_msg,
  output logic other_msg,
  output logic loop_req,
  output logic rtn_req
);
  // only messages carrying our address may steer the loop
  assign own_msg = valid && (addr == rlc_pkg::OWN_ADDR);
  assign other_msg = valid && (addr != rlc_pkg::OWN_ADDR);
  assign loop_req = own_msg && (code == rlc_pkg::CODE_LOOP_REQ);
  assign rtn_req = own_msg && (code == rlc_pkg::CODE_RTN);
endmodule

// *** bench/rlc_checker.sv ***
// port assertions for the loopback control
// assumes bind onto rlc_ctrl, one hclk domain
`timescale 1ns/10ps
module rlc_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // line and eoc inputs
  input wire logic los_lfa_net,
  input wire logic los_lfa_cust,
  input wire logic net_link_active,
  input wire logic eoc_rx_valid,
  input wire logic [1:0] eoc_rx_addr,
  input wire logic [7:0] eoc_rx_code,
  input wire logic [7:0] ind_rx_net,
  input wire logic [7:0] ind_rx_cust,
  input wire logic [7:0] ind_local,
  // outputs watched
  input wire logic [7:0] ind_tx_net,
  input wire logic eoc_tx_valid,
  input wire logic [1:0] eoc_tx_addr,
  input wire logic [7:0] eoc_tx_code,
  input wire logic deact_net,
  input wire logic deact_cust,
  input wire logic cust_start,
  input wire logic loop_en,
  input wire logic cust_fwd_en
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // message classes; loss outranks any message
  logic los, own, rtn, lreq;
  assign los = los_lfa_net | los_lfa_cust;
  assign own = eoc_rx_valid && eoc_rx_addr == rlc_pkg::OWN_ADDR && !los;
  assign rtn = own && eoc_rx_code == rlc_pkg::CODE_RTN;
  assign lreq = own && eoc_rx_code == rlc_pkg::CODE_LOOP_REQ;
  a_loss_deact: assert property (los |=> deact_net && deact_cust && !loop_en)
    else $error("loss did not drop both sides");
  a_no_self: assert property (!loop_en && !lreq |=> !loop_en)
    else $error("loop closed unasked");
  a_loop_close: assert property (lreq |=> loop_en)
    else $error("loop not closed");
  a_loop_hold: assert property (loop_en && !los && !rtn |=> loop_en)
    else $error("loop dropped early");
  a_rtn_cancel: assert property (loop_en && rtn |=> !loop_en && deact_cust
    && cust_start == $past(net_link_active))
    else $error("return to normal mishandled");
  a_hold_ins: assert property (loop_en && eoc_rx_valid && !los
    && eoc_rx_addr != rlc_pkg::OWN_ADDR |=> eoc_tx_valid
    && eoc_tx_code == rlc_pkg::CODE_HOLD && eoc_tx_addr == rlc_pkg::OWN_ADDR)
    else $error("hold state not sent");
  a_fwd_on: assert property (loop_en |-> cust_fwd_en)
    else $error("loop not transparent");
  // indicators switch source in the same cycle as the loop, so the present
  // loop_en selects; inputs were taken one cycle earlier
  a_ind_merge: assert property ($past(hresetn) |-> ind_tx_net ==
    (((loop_en ? $past(ind_rx_net) : $past(ind_rx_cust)) & ~rlc_pkg::REG_IND_MASK)
    | ($past(ind_local) & rlc_pkg::REG_IND_MASK)))
    else $error("indicator merge wrong");
endmodule
bind rlc_ctrl rlc_checker u_chk (.hclk, .hresetn, .los_lfa_net, .los_lfa_cust,
  .net_link_active, .eoc_rx_valid, .eoc_rx_addr, .eoc_rx_code, .ind_rx_net,
  .ind_rx_cust, .ind_local, .ind_tx_net, .eoc_tx_valid, .eoc_tx_addr,
  .eoc_tx_code, .deact_net, .deact_cust, .cust_start, .loop_en, .cust_fwd_en);

// *** bench/rlc_ltu_model.sv ***
// ltu-side model sending deframed eoc messages
// assumes the bench calls send just after a rising edge
`timescale 1ns/10ps
module rlc_ltu_model (
  // clock
  input wire logic hclk,
  // eoc toward the regenerator
  output logic eoc_rx_valid,
  output logic [1:0] eoc_rx_addr,
  output logic [7:0] eoc_rx_code
);
  initial begin
    eoc_rx_valid = 1'b0;
    eoc_rx_addr = 2'h0;
    eoc_rx_code = 8'h00;
  end
  // loop request and return go out only when asked, at start-up or active link
  task automatic send(input logic [1:0] a, input logic [7:0] c);
    @(posedge hclk);
    eoc_rx_valid <= 1'b1;
    eoc_rx_addr <= a;
    eoc_rx_code <= c;
    @(posedge hclk);
    eoc_rx_valid <= 1'b0;
    eoc_rx_addr <= ~a; // stale fields flip so nobody reads a held value
    eoc_rx_code <= ~c;
  endtask
endmodule

// *** bench/regenerator_loopback_control_test.sv ***
// self-checking bench for rlc_ctrl with ltu model
// assumes ahb-lite single word transfers and hready from hreadyout
`timescale 1ns/10ps
module regenerator_loopback_control_test;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, los_lfa_net, los_lfa_cust;
  logic net_link_active, eoc_rx_valid, eoc_tx_valid, eoc_own_strobe, eoc_fwd_strobe;
  logic deact_net, deact_cust, cust_xcvr_rst, cust_start, loop_en, cust_fwd_en, irq;
  logic [1:0] htrans, eoc_rx_addr, eoc_tx_addr;
  logic [2:0] hsize;
  logic [7:0] haddr, eoc_rx_code, eoc_tx_code, ind_rx_net, ind_rx_cust, ind_local, ind_tx_net;
  logic [31:0] hwdata, hrdata, q;
  int failures = 0;
  int cmp_count = 0;
  rlc_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .los_lfa_net, .los_lfa_cust,
    .net_link_active, .eoc_rx_valid, .eoc_rx_addr, .eoc_rx_code, .ind_rx_net,
    .ind_rx_cust, .ind_local, .ind_tx_net, .eoc_tx_valid, .eoc_tx_addr, .eoc_tx_code,
    .eoc_own_strobe, .eoc_fwd_strobe, .deact_net, .deact_cust, .cust_xcvr_rst,
    .cust_start, .loop_en, .cust_fwd_en, .irq);
  rlc_ltu_model u_ltu (.hclk, .eoc_rx_valid, .eoc_rx_addr, .eoc_rx_code);
  always #2.5 hclk = ~hclk;
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // bounded wait for hready; a hang ends the run
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      end_of_test();
    end
  endtask
  // one single ahb transfer; q holds read data
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic msg(input logic [1:0] a, input logic [7:0] c);
    u_ltu.send(a, c);
    #1;
  endtask
  task automatic s_regs();
    ahb(1'b0, rlc_pkg::CTRL_OFF, 32'h0);
    chk(q, 32'h1, "ctrl reset");
    chk(hresp, 1'b0, "okay response");
    ahb(1'b1, 8'h10, 32'hFFFFFFFF);
    ahb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0, "unmapped");
  endtask
  task automatic s_close();
    int n;
    msg(rlc_pkg::OWN_ADDR, rlc_pkg::CODE_LOOP_REQ);
    chk(loop_en, 1'b1, "loop closed");
    chk(cust_xcvr_rst, 1'b1, "cust reset");
    chk(irq, 1'b0, "masked irq");
    // the reset pulse is counted so its width cannot drift unseen
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (cust_xcvr_rst === 1'b1 && n < 300);
    chk(n, rlc_pkg::RST_CYC, "reset length");
    if (n >= 300) begin
      end_of_test();
    end
    @(posedge hclk);
    #1;
    chk(ind_tx_net, 8'h9A, "looped ind");
    ahb(1'b0, rlc_pkg::STAT_OFF, 32'h0);
    chk(q & 32'h4C, 32'h4C, "status");
    ahb(1'b1, rlc_pkg::IRQ_MASK_OFF, 32'hF);
    #1;
    chk(irq, 1'b1, "irq up");
    ahb(1'b0, rlc_pkg::IRQ_STAT_OFF, 32'h0);
    chk(q, 32'h1, "close event");
    @(posedge hclk);
    #1;
    chk(irq, 1'b0, "irq cleared");
  endtask
  task automatic s_inloop();
    msg(2'h1, 8'h33);
    chk(eoc_tx_valid, 1'b1, "hold sent");
    chk(eoc_tx_code, rlc_pkg::CODE_HOLD, "hold code");
    chk(eoc_tx_addr, rlc_pkg::OWN_ADDR, "hold addr");
    msg(rlc_pkg::OWN_ADDR, 8'h20);
    chk(eoc_own_strobe, 1'b1, "own msg");
    chk(loop_en, 1'b1, "loop kept");
    msg(rlc_pkg::OWN_ADDR, rlc_pkg::CODE_LOOP_REQ);
    chk({eoc_own_strobe, loop_en}, 2'b11, "repeat request");
  endtask
  task automatic s_return();
    msg(rlc_pkg::OWN_ADDR, rlc_pkg::CODE_RTN);
    chk(loop_en, 1'b0, "loop off");
    chk(deact_cust, 1'b1, "cust off");
    chk(cust_start, 1'b1, "restart");
    ahb(1'b0, rlc_pkg::IRQ_STAT_OFF, 32'h0);
    chk(q, 32'hA, "hold and cancel");
  endtask
  // link toward the ltu not up and ctrl reset bit cleared: loop without transceiver reset, no restart on return
  task automatic s_startup();
    @(posedge hclk);
    net_link_active <= 1'b0;
    ahb(1'b1, rlc_pkg::CTRL_OFF, 32'h0);
    ahb(1'b0, rlc_pkg::CTRL_OFF, 32'h0);
    chk(q, 32'h0, "ctrl written");
    msg(2'h1, 8'h33);
    chk({eoc_fwd_strobe, eoc_tx_valid}, 2'b10, "foreign passed on");
    msg(rlc_pkg::OWN_ADDR, rlc_pkg::CODE_LOOP_REQ);
    chk({loop_en, cust_xcvr_rst}, 2'b10, "start-up close");
    ahb(1'b0, rlc_pkg::STAT_OFF, 32'h0);
    chk(q & 32'hC3, 32'h2, "loop state");
    msg(rlc_pkg::OWN_ADDR, rlc_pkg::CODE_RTN);
    chk({loop_en, deact_cust, cust_start}, 3'b010, "no restart");
    @(posedge hclk);
    net_link_active <= 1'b1;
  endtask
  task automatic s_loss();
    msg(rlc_pkg::OWN_ADDR, rlc_pkg::CODE_LOOP_REQ);
    @(posedge hclk);
    los_lfa_cust <= 1'b1;
    @(posedge hclk);
    los_lfa_cust <= 1'b0;
    #1;
    chk({deact_net, deact_cust, loop_en}, 3'b110, "loss");
  endtask
  // mid-run reset with the loop closed must drop it and restore defaults
  task automatic s_reset();
    msg(rlc_pkg::OWN_ADDR, rlc_pkg::CODE_LOOP_REQ);
    @(posedge hclk);
    hresetn <= 1'b0;
    #1;
    chk({loop_en, cust_fwd_en, cust_xcvr_rst, irq}, 4'b0100, "reset values");
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, rlc_pkg::CTRL_OFF, 32'h0);
    chk(q, 32'h1, "ctrl after reset");
  endtask
  // inputs at time zero, reset for six cycles
  initial begin
    hclk = 1'b0;
    {hresetn, hsel, hwrite, los_lfa_net, los_lfa_cust, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    net_link_active = 1'b1;
    ind_rx_net = 8'h5A;
    ind_rx_cust = 8'hC3;
    ind_local = 8'h96;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    s_regs();
    s_close();
    s_inloop();
    s_return();
    s_startup();
    s_loss();
    s_reset();
    end_of_test();
  end
endmodule
